// [dv/tlc_checker.sv]
// tlc_checker.sv: port assertions for the tricolor sink controller.
// assumes: bound into tlc_top; scl low phases last several clocks.
`timescale 1ns/1ns
module tlc_checker (
  input wire       ref_clk,
  input wire       rst,
  input wire       scl,
  input wire       sda_oe,
  input wire       red_sink,
  input wire       green_sink,
  input wire       blue_sink,
  input wire       sink_or_switch_select,
  input wire [1:0] red_current_code,
  input wire [1:0] green_current_code,
  input wire [1:0] blue_current_code
);
  // ----
  // clocks since the last scl fall
  // ----
  reg        scl_r;
  reg  [3:0] age_r;
  wire [5:0] code_w;
  assign code_w = {red_current_code, green_current_code, blue_current_code};
  always @(posedge ref_clk) begin
    scl_r <= scl;
    if (rst)
      age_r <= 4'hf;
    else if (scl_r && !scl)
      age_r <= 4'h0;
    else if (age_r != 4'hf)
      age_r <= age_r + 4'h1;
  end
  // ----
  // assertions
  // ----
  default clocking dc @(posedge ref_clk);
  endclocking
  a_rst_switch: assert property (rst |=> sink_or_switch_select)
    else $error("switch mode lost in reset");
  a_rst_dark: assert property (rst |=> !(red_sink | green_sink | blue_sink))
    else $error("sink lit in reset");
  a_rst_codes: assert property (rst |=> code_w == 6'h00)
    else $error("current code not cleared");
  a_rst_quiet: assert property (rst |=> !sda_oe)
    else $error("sda pulled in reset");
  a_oe_on_fall: assert property (disable iff (rst) $changed(sda_oe) |-> age_r <= 4'h6)
    else $error("sda moved away from scl fall");
  a_code_on_fall: assert property (disable iff (rst) $changed(code_w) |-> age_r <= 4'h6)
    else $error("current code moved off a write");
  a_mode_on_fall: assert property (disable iff (rst)
    $changed(sink_or_switch_select) |-> age_r <= 4'h6)
    else $error("mode moved off a write");
  a_ack_release: assert property (disable iff (rst) $rose(sda_oe) |-> ##[1:200] !sda_oe)
    else $error("sda held too long");
endmodule
bind tlc_top tlc_checker chk_u (.ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_oe(sda_oe),
  .red_sink(red_sink), .green_sink(green_sink), .blue_sink(blue_sink),
  .sink_or_switch_select(sink_or_switch_select), .red_current_code(red_current_code),
  .green_current_code(green_current_code), .blue_current_code(blue_current_code));

// [dv/tlc_host.sv]
// tlc_host.sv: i2c master model for the host side of the bus.
// assumes: sda_w is the resolved open-drain wire with a pull-up.
`timescale 1ns/1ns
module tlc_host #(
  parameter [6:0] DEV_ADDR = 7'h2c
) (
  input  wire ref_clk,
  input  wire sda_w,
  output reg  scl,
  output reg  sda_drv
);
  integer nak_cnt;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    nak_cnt = 0;
  end
  task hc(input integer n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // data moves mid-low, sampled late in the high phase
  task bit_io(input b, output q);
    hc(2);
    sda_drv = b;
    hc(2);
    scl = 1'b1;
    hc(4);
    q = sda_w;
    scl = 1'b0;
  endtask
  // long low first so a pending ack is released
  task start;
    sda_drv = 1'b1;
    hc(4);
    scl = 1'b1;
    hc(4);
    sda_drv = 1'b0;
    hc(4);
    scl = 1'b0;
  endtask
  task stop;
    sda_drv = 1'b0;
    hc(4);
    scl = 1'b1;
    hc(4);
    sda_drv = 1'b1;
    hc(4);
  endtask
  task xbyte(input [7:0] d, input rd, output [7:0] q);
    integer i;
    reg     a;
    for (i = 7; i >= 0; i = i - 1)
      bit_io(d[i], q[i]);
    bit_io(1'b1, a);
    if (a && !rd)
      nak_cnt = nak_cnt + 1;
  endtask
  task head(input [7:0] a);
    reg [7:0] q;
    start;
    xbyte({DEV_ADDR, 1'b0}, 1'b0, q);
    xbyte(a, 1'b0, q);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg [7:0] q;
    head(a);
    xbyte(d, 1'b0, q);
    stop;
  endtask
  // two data bytes at a and a+1 in one transfer
  task wr2(input [7:0] a, input [7:0] d0, input [7:0] d1);
    reg [7:0] q;
    head(a);
    xbyte(d0, 1'b0, q);
    xbyte(d1, 1'b0, q);
    stop;
  endtask
  // master acks the first byte so the slave goes on to send the byte at a+1
  task rd2(input [7:0] a, output [7:0] d0, output [7:0] d1);
    integer   i;
    reg       k;
    reg [7:0] q;
    head(a);
    start;
    xbyte({DEV_ADDR, 1'b1}, 1'b0, q);
    for (i = 7; i >= 0; i = i - 1)
      bit_io(1'b1, d0[i]);
    bit_io(1'b0, k);
    xbyte(8'hff, 1'b1, d1);
    stop;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    reg [7:0] q;
    head(a);
    start;
    xbyte({DEV_ADDR, 1'b1}, 1'b0, q);
    xbyte(8'hff, 1'b1, d);
    stop;
  endtask
endmodule

// [dv/tlc_top_tb.sv]
// tlc_top_tb.sv: self-checking bench for the tricolor sink controller.
// assumes: tlc_host is the bus master; the pwm frame is cut to 96 clocks.
`timescale 1ns/1ns
module tlc_top_tb;
  localparam FR = 96;
  // red, green twelfths per hue code; blue takes the rest
  localparam [127:0] TBL = 128'hc00c0066066044633636339309390330;
  reg         ref_clk;
  reg         rst;
  reg         ext_dim_pin;
  wire        scl;
  wire        sda_drv;
  wire        sda_out;
  wire        sda_oe;
  wire        sda_w;
  wire        swm;
  wire [2:0]  snk;
  wire [5:0]  cod;
  integer     n_mismatch;
  integer     tests_run;
  integer     seed;
  integer     k;
  reg  [31:0] r1;
  reg  [31:0] r2;
  reg  [7:0]  rv;
  assign sda_w = sda_drv & (sda_oe ? sda_out : 1'b1);
  tlc_top #(.FRAME_CYC(FR)) dut_u (.ref_clk(ref_clk), .rst(rst), .scl(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .ext_dim_pin(ext_dim_pin),
    .red_sink(snk[2]), .green_sink(snk[1]), .blue_sink(snk[0]),
    .sink_or_switch_select(swm), .red_current_code(cod[5:4]),
    .green_current_code(cod[3:2]), .blue_current_code(cod[1:0]));
  tlc_host host_u (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl), .sda_drv(sda_drv));
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;
  task chk(input string nm, input [31:0] e, input [31:0] s);
    tests_run = tests_run + 1;
    if (s !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("Error %0s expected %h seen %h", nm, e, s);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // packed on-times over one frame: {overlap, red, green, blue}
  function [31:0] expc(input [7:0] c, input [7:0] h, input [7:0] g, input e);
    integer   l;
    integer   s1;
    integer   s2;
    reg [2:0] on;
    l = h[3:1] == 3'h0 ? 0 : FR >> (7 - h[3:1]);
    if (!c[7])
      l = FR;
    s1 = l * TBL[127 - 8 * h[7:4] -: 4] / 12;
    s2 = l * (TBL[127 - 8 * h[7:4] -: 4] + TBL[123 - 8 * h[7:4] -: 4]) / 12;
    on = c[6] ? c[3:1] & ~(g[3:1] & {3{g[0] & ~e}}) : 3'h0;
    if (!c[7] || h[0])
      expc = {(on & (on - 3'h1)) != 3'h0 ? l[7:0] : 8'h0, on[2] ? l[7:0] : 8'h0,
              on[1] ? l[7:0] : 8'h0, on[0] ? l[7:0] : 8'h0};
    else
      expc = {8'h0, on[2] ? s1[7:0] : 8'h0, on[1] ? s2[7:0] - s1[7:0] : 8'h0,
              on[0] ? l[7:0] - s2[7:0] : 8'h0};
  endfunction
  task cfg(input [7:0] c, input [7:0] h, input [7:0] g, input e);
    integer    i;
    reg [31:0] n;
    host_u.wr(8'h00, c);
    host_u.wr(8'h01, h);
    host_u.wr(8'h06, g);
    ext_dim_pin = e;
    host_u.hc(8);
    n = 32'h0;
    for (i = 0; i < FR; i = i + 1) begin
      n = n + {7'h0, (snk & (snk - 3'h1)) != 3'h0, 7'h0, snk[2], 7'h0, snk[1], 7'h0, snk[0]};
      host_u.hc(1);
    end
    chk("mode", {31'h0, c[5]}, {31'h0, swm});
    chk("on time", expc(c, h, g, e), n);
  endtask
  task do_reset(input integer n);
    integer i;
    rst = 1'b1;
    host_u.hc(n);
    rst = 1'b0;
    host_u.hc(4);
    chk("reset pins", 32'h80, {21'h0, snk, swm, cod, sda_oe});
    for (i = 0; i < 7; i = i + 1) begin
      host_u.rd(i[7:0], rv);
      chk("reset regs", i == 0 ? 32'h20 : 32'h0, {24'h0, rv});
    end
    $display("test reset done");
  endtask
  initial begin
    seed = 32'h89a13040;
    n_mismatch = 0;
    tests_run = 0;
    ext_dim_pin = 1'b0;
    rst = 1'b1;
    do_reset(20);
    for (k = 0; k < 3; k = k + 1) begin
      host_u.wr(k[7:0], 8'hff);
      host_u.rd(k[7:0], rv);
      chk("reg mask", k == 0 ? 8'hee : k == 1 ? 8'hff : 8'h3f, {24'h0, rv});
    end
    for (k = 0; k < 8; k = k + 1) begin
      r1 = $random(seed);
      rv = k < 4 ? {2'h0, k[1:0], k[1:0], k[1:0]} : r1[7:0];
      host_u.wr(8'h02, rv);
      chk("codes", {26'h0, rv[5:0]}, {26'h0, cod});
    end
    r1 = $random(seed);
    host_u.wr2(8'h01, r1[7:0], r1[15:8]);
    host_u.rd2(8'h01, r2[15:8], r2[7:0]);
    chk("burst", {16'h0, r1[7:0], r1[15:8] & 8'h3f}, {16'h0, r2[15:8], r2[7:0]});
    $display("test registers done");
    for (k = 0; k < 16; k = k + 1)
      cfg(8'hce, {k[3:0], 4'he}, 8'h00, 1'b0);
    for (k = 0; k < 16; k = k + 1)
      cfg(8'hee, {4'h7, k[2:0], k[3]}, 8'h00, 1'b0);
    for (k = 0; k < 4; k = k + 1)
      cfg(k[1] ? 8'hce : 8'h4e, 8'h6f, 8'h0b, k[0]);
    $display("test pwm corners done");
    for (k = 0; k < 16; k = k + 1) begin
      r1 = $random(seed);
      r2 = $random(seed);
      cfg(r1[7:0], r1[15:8], r1[23:16], r2[0]);
    end
    $display("test random done");
    do_reset(4);
    chk("acks", 32'h0, host_u.nak_cnt);
    end_of_test;
  end
  initial begin
    repeat (80000) @(posedge ref_clk);
    n_mismatch = n_mismatch + 1;
    end_of_test;
  end
endmodule

// [inc/tlc_map.vh]
// tlc_map.vh: register map, field positions, reset values and timing
// of the tricolor sink controller.
// assumes: included by bare name from the design file.
`ifndef TLC_MAP_VH
`define TLC_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TLC_REG_CTRL      8'h00
`define TLC_REG_HUE       8'h01
`define TLC_REG_CUR       8'h02
`define TLC_REG_GPIO      8'h06

// ----------------------------------------
// led_trio_control fields
// ----------------------------------------
`define TLC_CTRL_PWM      7
`define TLC_CTRL_TRIO     6
`define TLC_CTRL_SWMODE   5
`define TLC_CTRL_RED      3
`define TLC_CTRL_GRN      2
`define TLC_CTRL_BLU      1
`define TLC_CTRL_MASK     8'hee
`define TLC_CTRL_RST      8'h20

// ----------------------------------------
// hue_and_intensity, sink_current_limit, gpio control fields
// ----------------------------------------
`define TLC_HUE_MSB       7
`define TLC_HUE_LSB       4
`define TLC_INT_MSB       3
`define TLC_INT_LSB       1
`define TLC_HUE_OVL       0
`define TLC_HUE_RST       8'h00
`define TLC_CUR_MASK      8'h3f
`define TLC_CUR_RST       8'h00
`define TLC_GPIO_EXTSEL   0
`define TLC_GPIO_RGATE    3
`define TLC_GPIO_GGATE    2
`define TLC_GPIO_BGATE    1
`define TLC_GPIO_MASK     8'h0f
`define TLC_GPIO_RST      8'h00

// ----------------------------------------
// timing and pwm arithmetic
// ----------------------------------------
`define TLC_CLK_NS        40
`define TLC_FRAME_US      50
`define TLC_FRAME_CYC     ((`TLC_FRAME_US * 1000) / `TLC_CLK_NS)
`define TLC_SHARE_FULL    4'hc
`define TLC_INT_FULL      3'h7
`define TLC_INT_OFF       3'h0

`endif

// [rtl/tlc_top.v]
// tlc_top.v: tricolor sink controller with i2c register slave,
// internal pwm engine, direct on/off and external dimming gate.
// assumes: scl, sda and ext_dim_pin are asynchronous pins; the sda
// wire is resolved outside from sda_oe (drive low when high).
//
// Contract
// - swmode bit five picks switch or current
// - reset leaves sinks in switch mode
// - internal pwm needs pwm and trio bits
// - per-sink on bits three, two, one
// - intensity code decodes logarithmically, 1/64 up
// - hue code gives fixed slot shares
// - overlap bit zero of colour register
// - hue shares only in non-overlap mode
// - overlap mode: sinks on together, duty only
// - 50us frame, slots shrink by brightness
// - trio without pwm follows on bits
// - trio bit low holds sinks off
// - 2-bit current code per sink
// - external dimming needs pin select, trio
// - gate selected sinks off while input low
// - ext direct, or gating internal pwm
// - pwm frame rate 20 khz
// - reset restores all register defaults
`timescale 1ns/1ns
`include "tlc_map.vh"

module tlc_top #(
  parameter [6:0] DEV_ADDR  = 7'h2c,
  parameter       CNT_W     = 11,
  parameter       FRAME_CYC = `TLC_FRAME_CYC
) (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       scl,
  input  wire       sda_in,
  output wire       sda_out,
  output reg        sda_oe,
  input  wire       ext_dim_pin,
  output reg        red_sink,
  output reg        green_sink,
  output reg        blue_sink,
  output reg        sink_or_switch_select,
  output wire [1:0] red_current_code,
  output wire [1:0] green_current_code,
  output wire [1:0] blue_current_code
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // share table in twelfths: {red, green, blue}
  function [11:0] hue_shares;
    input [3:0] code;
    begin
      case (code)
        4'h0:    hue_shares = 12'hc00;
        4'h1:    hue_shares = 12'h0c0;
        4'h2:    hue_shares = 12'h00c;
        4'h3:    hue_shares = 12'h660;
        4'h4:    hue_shares = 12'h066;
        4'h5:    hue_shares = 12'h606;
        4'h6:    hue_shares = 12'h444;
        4'h7:    hue_shares = 12'h633;
        4'h8:    hue_shares = 12'h363;
        4'h9:    hue_shares = 12'h363;
        4'ha:    hue_shares = 12'h336;
        4'hb:    hue_shares = 12'h930;
        4'hc:    hue_shares = 12'h093;
        4'hd:    hue_shares = 12'h390;
        4'he:    hue_shares = 12'h039;
        default: hue_shares = 12'h309;
      endcase
    end
  endfunction

  // part of the lit time given by a share in twelfths
  function [CNT_W-1:0] scale_len;
    input [CNT_W-1:0] len;
    input [3:0]       tw;
    reg   [CNT_W+3:0] prod;
    begin
      prod      = (len * tw) / `TLC_SHARE_FULL;
      scale_len = prod[CNT_W-1:0];
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [1:0] scl_sync_r;
  reg [1:0] sda_sync_r;
  reg [1:0] ext_sync_r;
  reg       scl_d_r;
  reg       sda_d_r;

  always @(posedge ref_clk) begin
    if (rst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      ext_sync_r <= 2'h0;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      ext_sync_r <= {ext_sync_r[0], ext_dim_pin};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  wire scl_s    = scl_sync_r[1];
  wire sda_s    = sda_sync_r[1];
  wire ext_s    = ext_sync_r[1];
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] ctrl_r;
  reg [7:0] hue_r;
  reg [7:0] cur_r;
  reg [7:0] gpio_r;
  reg [7:0] rd_mux;
  wire       wr_stb;
  wire [7:0] wr_data;
  reg  [7:0] ptr_r;

  always @* begin
    case (ptr_r)
      `TLC_REG_CTRL: rd_mux = ctrl_r;
      `TLC_REG_HUE:  rd_mux = hue_r;
      `TLC_REG_CUR:  rd_mux = cur_r;
      `TLC_REG_GPIO: rd_mux = gpio_r;
      default:       rd_mux = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= `TLC_CTRL_RST;
      hue_r  <= `TLC_HUE_RST;
      cur_r  <= `TLC_CUR_RST;
      gpio_r <= `TLC_GPIO_RST;
    end else if (wr_stb) begin
      case (ptr_r)
        `TLC_REG_CTRL: ctrl_r <= wr_data & `TLC_CTRL_MASK;
        `TLC_REG_HUE:  hue_r  <= wr_data;
        `TLC_REG_CUR:  cur_r  <= wr_data & `TLC_CUR_MASK;
        `TLC_REG_GPIO: gpio_r <= wr_data & `TLC_GPIO_MASK;
        default:       ctrl_r <= ctrl_r;
      endcase
    end
  end

  assign red_current_code   = cur_r[5:4];
  assign green_current_code = cur_r[3:2];
  assign blue_current_code  = cur_r[1:0];

  // ----------------------------------------
  // i2c slave
  // ----------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_AACK  = 3'h2;
  localparam [2:0] ST_WBYTE = 3'h3;
  localparam [2:0] ST_WACK  = 3'h4;
  localparam [2:0] ST_RBYTE = 3'h5;
  localparam [2:0] ST_RACK  = 3'h6;

  reg [2:0] st_r;
  reg [3:0] bit_r;
  reg [7:0] shift_r;
  reg       rnw_r;
  reg       first_r;
  reg       master_ack_r;

  assign sda_out = 1'b0;
  assign wr_stb  = (st_r == ST_WBYTE) & scl_fall & (bit_r == 4'h8) & ~first_r;
  assign wr_data = shift_r;

  always @(posedge ref_clk) begin
    if (rst) begin
      st_r         <= ST_IDLE;
      bit_r        <= 4'h0;
      shift_r      <= 8'h00;
      rnw_r        <= 1'b0;
      first_r      <= 1'b0;
      master_ack_r <= 1'b0;
      ptr_r        <= 8'h00;
      sda_oe       <= 1'b0;
    end else if (bus_start) begin
      st_r   <= ST_ADDR;
      bit_r  <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      st_r   <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        ST_ADDR, ST_WBYTE: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_r   <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            bit_r <= 4'h0;
            if (st_r == ST_ADDR) begin
              if (shift_r[7:1] == DEV_ADDR) begin
                rnw_r   <= shift_r[0];
                first_r <= ~shift_r[0];
                sda_oe  <= 1'b1;
                st_r    <= ST_AACK;
              end else begin
                st_r <= ST_IDLE;
              end
            end else begin
              if (first_r)
                ptr_r <= shift_r;
              else
                ptr_r <= ptr_r + 8'h01;
              first_r <= 1'b0;
              sda_oe  <= 1'b1;
              st_r    <= ST_WACK;
            end
          end
        end
        ST_AACK, ST_WACK: begin
          if (scl_fall) begin
            if (rnw_r) begin
              shift_r <= {rd_mux[6:0], 1'b0};
              sda_oe  <= ~rd_mux[7];
              bit_r   <= 4'h1;
              st_r    <= ST_RBYTE;
            end else begin
              sda_oe <= 1'b0;
              st_r   <= ST_WBYTE;
            end
          end
        end
        ST_RBYTE: begin
          if (scl_fall) begin
            if (bit_r == 4'h8) begin
              sda_oe <= 1'b0;
              ptr_r  <= ptr_r + 8'h01;
              st_r   <= ST_RACK;
            end else begin
              sda_oe  <= ~shift_r[7];
              shift_r <= {shift_r[6:0], 1'b0};
              bit_r   <= bit_r + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            master_ack_r <= ~sda_s;
          end else if (scl_fall) begin
            if (master_ack_r) begin
              shift_r <= {rd_mux[6:0], 1'b0};
              sda_oe  <= ~rd_mux[7];
              bit_r   <= 4'h1;
              st_r    <= ST_RBYTE;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // pwm frame
  // ----------------------------------------
  reg  [CNT_W-1:0] frame_r;
  wire [CNT_W-1:0] frame_len = FRAME_CYC[CNT_W-1:0];

  always @(posedge ref_clk) begin
    if (rst)
      frame_r <= {CNT_W{1'b0}};
    else if (frame_r == frame_len - {{(CNT_W-1){1'b0}}, 1'b1})
      frame_r <= {CNT_W{1'b0}};
    else
      frame_r <= frame_r + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  wire [2:0]  int_code = hue_r[`TLC_INT_MSB:`TLC_INT_LSB];
  wire [3:0]  hue_code = hue_r[`TLC_HUE_MSB:`TLC_HUE_LSB];
  wire        overlap  = hue_r[`TLC_HUE_OVL];
  wire [11:0] shares   = hue_shares(hue_code);

  wire [CNT_W-1:0] lit_len = (int_code == `TLC_INT_OFF) ? {CNT_W{1'b0}} :
                             (frame_len >> (`TLC_INT_FULL - int_code));

  wire [CNT_W-1:0] red_end = scale_len(lit_len, shares[11:8]);
  wire [CNT_W-1:0] grn_end = scale_len(lit_len, shares[11:8] + shares[7:4]);
  wire [CNT_W-1:0] blu_end = scale_len(lit_len, shares[11:8] + shares[7:4] + shares[3:0]);

  reg pwm_r;
  reg pwm_g;
  reg pwm_b;

  always @* begin
    if (overlap) begin
      pwm_r = frame_r < lit_len;
      pwm_g = frame_r < lit_len;
      pwm_b = frame_r < lit_len;
    end else begin
      pwm_r = frame_r < red_end;
      pwm_g = (frame_r >= red_end) && (frame_r < grn_end);
      pwm_b = (frame_r >= grn_end) && (frame_r < blu_end);
    end
  end

  // ----------------------------------------
  // sink drive
  // ----------------------------------------
  wire pwm_on   = ctrl_r[`TLC_CTRL_PWM];
  wire trio_on  = ctrl_r[`TLC_CTRL_TRIO];
  wire ext_used = gpio_r[`TLC_GPIO_EXTSEL] & trio_on;

  wire [2:0] on_bits = {ctrl_r[`TLC_CTRL_RED], ctrl_r[`TLC_CTRL_GRN],
                        ctrl_r[`TLC_CTRL_BLU]};
  wire [2:0] gates   = {gpio_r[`TLC_GPIO_RGATE], gpio_r[`TLC_GPIO_GGATE],
                        gpio_r[`TLC_GPIO_BGATE]};
  wire [2:0] ipwm    = {pwm_r, pwm_g, pwm_b};

  reg [2:0] drive;
  reg [2:0] base;

  always @* begin
    base = pwm_on ? ipwm : 3'h7;
    drive = base & ~(gates & {3{ext_used & ~ext_s}});
    drive = drive & on_bits;
    if (!trio_on)
      drive = 3'h0;
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      red_sink              <= 1'b0;
      green_sink            <= 1'b0;
      blue_sink             <= 1'b0;
      sink_or_switch_select <= 1'b1;
    end else begin
      red_sink              <= drive[2];
      green_sink            <= drive[1];
      blue_sink             <= drive[0];
      sink_or_switch_select <= ctrl_r[`TLC_CTRL_SWMODE];
    end
  end

endmodule
